/* rtl/asr_pkg.sv */
// Purpose: shared constants for the serial receiver and its far-end transmitter
// Assumes: 100 MHz system clock, one clock domain
// Notes: register offsets are byte addresses of aligned 32-bit words
package asr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ASR_CTRL_OFS = 8'h00;
  localparam logic [7:0] ASR_BAUD_OFS = 8'h04;
  localparam logic [7:0] ASR_STAT_OFS = 8'h08;
  localparam logic [7:0] ASR_DATA_OFS = 8'h0C;
  localparam logic [7:0] ASR_IRQS_OFS = 8'h10;
  localparam logic [7:0] ASR_MASK_OFS = 8'h14;
  // ctrl bits
  localparam int ASR_C_PORT_EN = 0;
  localparam int ASR_C_SYNC = 1;
  localparam int ASR_C_NINTH = 2;
  localparam int ASR_C_RX_EN = 3;
  localparam int ASR_C_ADDR_DET = 4;
  localparam int ASR_C_HI_SPEED = 5;
  localparam int ASR_C_DIV16 = 6;
  localparam int ASR_C_RX_IE = 7;
  localparam int ASR_C_GLB_IE = 8;
  localparam int ASR_C_PER_IE = 9;
  localparam int ASR_C_DIR_RX = 10;
  localparam int ASR_C_DIR_CK = 11;
  localparam int ASR_CTRL_W = 12;
  // status bits
  localparam int ASR_S_NINTH = 0;
  localparam int ASR_S_OVR = 1;
  localparam int ASR_S_FERR = 2;
  localparam int ASR_S_FULL = 3;
  localparam int ASR_S_IDLE = 4;
  // irq status bits
  localparam int ASR_I_RX = 0;
  localparam int ASR_I_OVR = 1;
  localparam int ASR_I_FERR = 2;
  localparam int ASR_IRQ_W = 3;
  // ****************************************
  // baud
  // ****************************************
  localparam logic [2:0] ASR_OVS = 3'h4;
  localparam logic [15:0] ASR_BAUD_RST = 16'h0000;
  localparam logic [3:0] ASR_NBITS_8 = 4'h8;
  localparam logic [3:0] ASR_NBITS_9 = 4'h9;
  localparam logic [3:0] ASR_MID_TICK = 4'h7;
  localparam logic [3:0] ASR_LAST_TICK = 4'hF;
  typedef enum logic [1:0] {ASR_IDLE, ASR_START, ASR_DATA, ASR_STOP} asr_state_t;

  // divisor select: async low speed divides by 64, high by 16, 16-bit by 16 or 4
  function automatic logic [21:0] asr_period(input logic [15:0] div, input logic hs,
                                               input logic div16);
    logic [21:0] n;
    n = {6'h00, (div16 ? div : {8'h00, div[7:0]})} + 22'h000001;
    if (!div16 && !hs) asr_period = {n[15:0], 6'h00};
    else if (div16 && hs) asr_period = {n[19:0], 2'h0};
    else asr_period = {n[17:0], 4'h0};
  endfunction : asr_period
endpackage : asr_pkg

/* rtl/asr_link_if.sv */
// Purpose: serial line between remote transmitter and receiver
// Assumes: one clock, line idles high
// Notes: the clock pin is carried as an input-only pin of the receiver
`timescale 1ns/100ps
interface asr_link_if;
  logic line;
  logic ck;
  modport rx (input line, input ck);
  modport tx (output line, output ck);
endinterface : asr_link_if

/* rtl/asr_rx.sv */
// Purpose: async serial receiver with 9-bit address detect, APB registers
// Assumes: line synchronous to clk_i, apb slave with zero wait states
// Notes: single-entry receive buffer
// Notes on behaviour
// - bit timing from divisor and speed selects
// - software sets both pin directions to input
// - runs only with enable set, sync clear
// - interrupt needs receive, global, peripheral enables
// - nine data bits when ninth-bit enable set
// - accept characters only while receive enabled
// - buffer load sets receive flag and interrupt
// - status shows head errors and ninth bit
// - data read returns low eight bits
// - clearing receive enable clears overrun
// - address detect needs ninth-bit enable too
// - address mode keeps only ninth-bit-one characters
// - address mode ninth bit reads one
// - address detect cleared: all characters buffered
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module asr_rx import asr_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  asr_link_if.rx link
);
  // ****************************************
  // registers
  // ****************************************
  logic [ASR_CTRL_W-1:0] ctrl_r;
  logic [15:0] baud_r;
  logic [ASR_IRQ_W-1:0] irqs_r;
  logic [ASR_IRQ_W-1:0] mask_r;
  logic [8:0] buf_r;
  logic buf_full_r;
  logic buf_ferr_r;
  logic ovr_flag_r;
  logic rd_full_r;
  logic [31:0] rdata_nxt;
  asr_state_t state_r;
  logic [21:0] tick_cnt_r;
  logic [3:0] os_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [8:0] shift_r;
  logic wr_en;
  logic rd_en;
  logic data_rd;
  logic tick;
  logic run;
  logic done;
  logic stop_ok;
  logic [8:0] rx_char;
  logic keep;
  logic load;
  logic ovr_ev;
  logic [21:0] period;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign data_rd = rd_en && (paddr_i == ASR_DATA_OFS) && rd_full_r;
  assign pready_o = 1'b1;
  assign run = ctrl_r[ASR_C_PORT_EN] && !ctrl_r[ASR_C_SYNC];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= '0;
      baud_r <= ASR_BAUD_RST;
      mask_r <= '0;
    end else if (wr_en) begin
      if (paddr_i == ASR_CTRL_OFS) begin
        ctrl_r <= pwdata_i[ASR_CTRL_W-1:0];
      end else if (paddr_i == ASR_BAUD_OFS) begin
        baud_r <= pwdata_i[15:0];
      end else if (paddr_i == ASR_MASK_OFS) begin
        mask_r <= pwdata_i[ASR_IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    pslverr_o = 1'b0;
    if (paddr_i == ASR_CTRL_OFS) begin
      rdata_nxt[ASR_CTRL_W-1:0] = ctrl_r;
    end else if (paddr_i == ASR_BAUD_OFS) begin
      rdata_nxt[15:0] = baud_r;
    end else if (paddr_i == ASR_STAT_OFS) begin
      rdata_nxt[ASR_S_NINTH] = buf_r[8];
      rdata_nxt[ASR_S_OVR] = ovr_flag_r;
      rdata_nxt[ASR_S_FERR] = buf_ferr_r;
      rdata_nxt[ASR_S_FULL] = buf_full_r;
      rdata_nxt[ASR_S_IDLE] = (state_r == ASR_IDLE);
    end else if (paddr_i == ASR_DATA_OFS) begin
      rdata_nxt[7:0] = buf_r[7:0];
    end else if (paddr_i == ASR_IRQS_OFS) begin
      rdata_nxt[ASR_IRQ_W-1:0] = irqs_r;
    end else if (paddr_i == ASR_MASK_OFS) begin
      rdata_nxt[ASR_IRQ_W-1:0] = mask_r;
    end else begin
      pslverr_o = psel_i && penable_i;
    end
  end

  // data captured in setup; a pop only counts if that capture saw a character
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h00000000;
      rd_full_r <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rdata_nxt;
      rd_full_r <= buf_full_r;
    end
  end

  // ****************************************
  // oversample tick, 16 per bit when the period is a multiple of 16
  // ****************************************
  assign period = asr_period(baud_r, ctrl_r[ASR_C_HI_SPEED], ctrl_r[ASR_C_DIV16]);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_r <= '0;
    end else if (!run || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 22'h000001;
    end
  end
  // period is in clocks per bit; shifting by four gives clocks per tick
  assign tick = run && (tick_cnt_r >= ({4'h0, period[21:4]} - 22'h000001));

  // ****************************************
  // frame receiver
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ASR_IDLE;
      os_cnt_r <= '0;
      bit_cnt_r <= '0;
      shift_r <= '0;
    end else if (!run || !ctrl_r[ASR_C_RX_EN]) begin
      state_r <= ASR_IDLE;
    end else if (tick) begin
      os_cnt_r <= os_cnt_r + 4'h1;
      case (state_r)
        ASR_IDLE: begin
          os_cnt_r <= '0;
          if (!link.line) state_r <= ASR_START;
        end
        ASR_START: begin
          if (os_cnt_r == ASR_MID_TICK) begin
            os_cnt_r <= '0;
            bit_cnt_r <= '0;
            state_r <= link.line ? ASR_IDLE : ASR_DATA;
          end
        end
        ASR_DATA: begin
          if (os_cnt_r == ASR_LAST_TICK) begin
            shift_r <= {link.line, shift_r[8:1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == (ctrl_r[ASR_C_NINTH] ? ASR_NBITS_9 : ASR_NBITS_8) - 4'h1)
              state_r <= ASR_STOP;
          end
        end
        default: begin
          if (os_cnt_r == ASR_LAST_TICK) state_r <= ASR_IDLE;
        end
      endcase
    end
  end

  assign done = tick && run && ctrl_r[ASR_C_RX_EN] && (state_r == ASR_STOP)
    && (os_cnt_r == ASR_LAST_TICK);
  assign stop_ok = link.line;
  assign rx_char = ctrl_r[ASR_C_NINTH] ? shift_r : {1'b0, shift_r[8:1]};
  // address filter only acts with nine-bit mode on
  assign keep = !(ctrl_r[ASR_C_ADDR_DET] && ctrl_r[ASR_C_NINTH])
    || rx_char[8];
  assign load = done && keep && !buf_full_r && !ovr_flag_r;
  assign ovr_ev = done && keep && buf_full_r && !ovr_flag_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_r <= '0;
      buf_full_r <= 1'b0;
      buf_ferr_r <= 1'b0;
    end else if (load) begin
      buf_r <= rx_char;
      buf_full_r <= 1'b1;
      buf_ferr_r <= !stop_ok;
    end else if (data_rd) begin
      buf_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovr_flag_r <= 1'b0;
    end else if (ovr_ev) begin
      ovr_flag_r <= 1'b1;
    end else if (!ctrl_r[ASR_C_RX_EN]) begin
      ovr_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irqs_r <= '0;
    end else begin
      // set wins over a write-one clear in the same cycle
      irqs_r <= (irqs_r & ~((wr_en && paddr_i == ASR_IRQS_OFS) ?
        pwdata_i[ASR_IRQ_W-1:0] : '0))
        | {load && !stop_ok, ovr_ev, load};
    end
  end
  assign irq_o = ctrl_r[ASR_C_RX_IE] && ctrl_r[ASR_C_GLB_IE] && ctrl_r[ASR_C_PER_IE]
    && |(irqs_r & mask_r);
endmodule : asr_rx

/* rtl/asr_tx.sv */
// Purpose: remote transmitter end driving the shared serial line
// Assumes: same clock and divisor as receiver
// Notes: one character per request, no buffer
`timescale 1ns/100ps
module asr_tx import asr_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] baud_div_i,
  input wire logic baud_high_speed_select_i,
  input wire logic baud_sixteen_bit_select_i,
  input wire logic ninth_bit_enable_i,
  input wire logic send_valid_i,
  input wire logic [8:0] send_data_i,
  output logic send_ready_o,
  asr_link_if.tx link
);
  logic [21:0] cnt_r;
  logic [3:0] bit_r;
  logic [10:0] sh_r;
  logic busy_r;
  logic [3:0] nbits;
  logic bit_end;
  assign nbits = ninth_bit_enable_i ? ASR_NBITS_9 : ASR_NBITS_8;
  assign bit_end = (cnt_r == asr_period(baud_div_i, baud_high_speed_select_i,
    baud_sixteen_bit_select_i) - 22'h000001);
  assign send_ready_o = !busy_r;
  assign link.line = busy_r ? sh_r[0] : 1'b1;
  assign link.ck = 1'b1;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '1;
    end else if (!busy_r) begin
      if (send_valid_i) begin
        busy_r <= 1'b1;
        cnt_r <= '0;
        bit_r <= '0;
        // start, data lsb first, stop
        sh_r <= ninth_bit_enable_i ? {1'b1, send_data_i, 1'b0}
          : {2'h3, send_data_i[7:0], 1'b0};
      end
    end else if (bit_end) begin
      cnt_r <= '0;
      sh_r <= {1'b1, sh_r[10:1]};
      bit_r <= bit_r + 4'h1;
      if (bit_r == nbits + 4'h1) busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 22'h000001;
    end
  end
endmodule : asr_tx

/* testbench/asr_properties.sv */
// Purpose: wire and interrupt checks beside the serial link
// Assumes: one clock, line idles high
// Notes: bit period fixed by the bench divisor
`timescale 1ns/100ps
module asr_properties #(parameter int PER = 16) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic line,
  input wire logic ck,
  input wire logic send_valid_i,
  input wire logic send_ready_o,
  input wire logic irq_o,
  input wire logic psel_i,
  input wire logic penable_i
);
  // ****************************************
  // run-length helpers
  // ****************************************
  logic prev_r;
  logic [15:0] run_r;
  logic [15:0] busy_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_r <= 1'b1;
      run_r <= 16'h0000;
      busy_r <= 16'h0000;
    end else begin
      prev_r <= line;
      run_r <= (line != prev_r) ? 16'h0001 : run_r + 16'h0001;
      busy_r <= send_ready_o ? 16'h0000 : busy_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence take_s;
    send_valid_i && send_ready_o;
  endsequence
  sequence start_s;
    ##[1:2] !line;
  endsequence
  chk_ck_high: assert property (ck)
    else $error("clock pin not held high");
  chk_idle_high: assert property (send_ready_o |-> line)
    else $error("line low while idle");
  chk_start_low: assert property (take_s |-> start_s)
    else $error("no start bit after request");
  // low runs only: idle highs have arbitrary length
  chk_bit_width: assert property ($rose(line) |-> run_r != 0 && int'(run_r) % PER == 0)
    else $error("low run not whole bit periods");
  // ten bit periods in 8-bit mode, eleven in 9-bit mode
  chk_frame_len: assert property ($rose(send_ready_o)
    |-> (int'(busy_r) == 10 * PER || int'(busy_r) == 11 * PER))
    else $error("frame length wrong");
  chk_stop_high: assert property ($rose(send_ready_o) |-> line && $past(line, 8))
    else $error("stop bit not high");
  chk_irq_rise: assert property ($rose(irq_o) |-> line)
    else $error("interrupt rose mid frame");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(psel_i && penable_i))
    else $error("interrupt fell without access");
endmodule : asr_properties

/* testbench/tb_asr_rx.sv */
// Purpose: receiver and transmitter ends joined on one link
// Assumes: divisor 0, sixteen-bit select, 16 clocks a bit
// Notes: rows first, then overrun recovery
`timescale 1ns/100ps
module tb_asr_rx import asr_pkg::*; ;
  // ****************************************
  // bench
  // ****************************************
  typedef struct {logic [11:0] c; logic [8:0] d; logic k; logic q;} asr_row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i, penable_i, pwrite_i, send_valid_i, nine_bit, er, tx_hs, tx_d16;
  logic [15:0] tx_div;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, irq_o, send_ready_o;
  logic [8:0] send_data_i;
  int err_count = 0;
  int n_checks = 0;
  asr_row_t rows [10] = '{
    '{12'hFC9, 9'h05A, 1'b1, 1'b1},
    '{12'hFCD, 9'h1A5, 1'b1, 1'b1},
    '{12'hFCD, 9'h03C, 1'b1, 1'b1},
    '{12'hFDD, 9'h155, 1'b1, 1'b1},
    '{12'hFDD, 9'h0AA, 1'b0, 1'b0},
    '{12'hFCD, 9'h033, 1'b1, 1'b1},
    '{12'hEC9, 9'h066, 1'b1, 1'b0},
    '{12'hFC1, 9'h011, 1'b0, 1'b0},
    '{12'hFC8, 9'h022, 1'b0, 1'b0},
    '{12'hFCB, 9'h044, 1'b0, 1'b0}};
  asr_link_if link ();
  asr_rx i_asr_rx (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .link(link.rx));
  asr_tx i_asr_tx (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .baud_div_i(tx_div),
    .baud_high_speed_select_i(tx_hs), .baud_sixteen_bit_select_i(tx_d16),
    .ninth_bit_enable_i(nine_bit), .send_valid_i(send_valid_i), .send_data_i(send_data_i),
    .send_ready_o(send_ready_o), .link(link.tx));
  asr_properties #(.PER(16)) i_asr_properties (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .line(link.line), .ck(link.ck), .send_valid_i(send_valid_i),
    .send_ready_o(send_ready_o), .irq_o(irq_o), .psel_i(psel_i), .penable_i(penable_i));
  always #5 clk_i = ~clk_i;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // waits out the whole frame so the receiver has loaded before reads
  task automatic send(input logic [8:0] d);
    @(posedge clk_i);
    send_valid_i <= 1'b1;
    send_data_i <= d;
    do @(posedge clk_i); while (send_ready_o !== 1'b1);
    send_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    do @(posedge clk_i); while (send_ready_o !== 1'b1);
    repeat (24) @(posedge clk_i);
  endtask : send
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    {psel_i, penable_i, pwrite_i, send_valid_i, nine_bit, tx_hs} = 6'h00;
    tx_d16 = 1'b1;
    tx_div = 16'h0000;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    send_data_i = 9'h000;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, ASR_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ASR_BAUD_OFS, 32'h0);
    apb(1'b1, ASR_MASK_OFS, 32'h7);
    foreach (rows[i]) begin
      nine_bit <= rows[i].c[ASR_C_NINTH];
      apb(1'b1, ASR_CTRL_OFS, {20'h0, rows[i].c});
      send(rows[i].d);
      chk({31'h0, irq_o}, {31'h0, rows[i].q});
      apb(1'b0, ASR_STAT_OFS, 32'h0);
      chk({31'h0, rd[ASR_S_FULL]}, {31'h0, rows[i].k});
      chk({30'h0, rd[ASR_S_FERR], rd[ASR_S_IDLE]}, 32'h1);
      if (rows[i].k) begin
        chk({31'h0, rd[ASR_S_NINTH]}, {31'h0, rows[i].d[8]});
        apb(1'b0, ASR_DATA_OFS, 32'h0);
        chk(rd, {24'h0, rows[i].d[7:0]});
      end
      apb(1'b1, ASR_IRQS_OFS, 32'h7);
    end
    apb(1'b1, ASR_CTRL_OFS, 32'hFC9);
    send(9'h011);
    send(9'h022);
    apb(1'b0, ASR_STAT_OFS, 32'h0);
    chk({30'h0, rd[ASR_S_OVR], rd[ASR_S_FULL]}, 32'h3);
    apb(1'b0, ASR_IRQS_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, ASR_DATA_OFS, 32'h0);
    chk(rd, 32'h11);
    send(9'h044);
    apb(1'b0, ASR_STAT_OFS, 32'h0);
    chk({31'h0, rd[ASR_S_FULL]}, 32'h0);
    apb(1'b1, ASR_CTRL_OFS, 32'hFC1);
    apb(1'b0, ASR_STAT_OFS, 32'h0);
    chk({31'h0, rd[ASR_S_OVR]}, 32'h0);
    apb(1'b1, ASR_IRQS_OFS, 32'h7);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // other divisor selects, each still giving sixteen clocks a bit
    tx_div <= 16'h0003;
    tx_hs <= 1'b1;
    apb(1'b1, ASR_BAUD_OFS, 32'h3);
    apb(1'b1, ASR_CTRL_OFS, 32'hFE9);
    send(9'h0C3);
    apb(1'b0, ASR_DATA_OFS, 32'h0);
    chk(rd, 32'hC3);
    // 8-bit divisor: high byte must be ignored
    tx_div <= 16'h0100;
    tx_d16 <= 1'b0;
    apb(1'b1, ASR_BAUD_OFS, 32'h100);
    apb(1'b1, ASR_CTRL_OFS, 32'hFA9);
    send(9'h081);
    apb(1'b0, ASR_DATA_OFS, 32'h0);
    chk(rd, 32'h81);
    stop_test();
  end
endmodule : tb_asr_rx
